// File: hdl/fpc_pkg.sv
// Shared constants for the fuse/ROM command link and its two ends
package fpc_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned BURN_SHORT_US = 250;
	localparam int unsigned BURN_LONG_MS = 262;
	localparam int unsigned BURN_SHORT_NS = BURN_SHORT_US * 1000;
	localparam int unsigned BURN_LONG_NS = BURN_LONG_MS * 1000000;
	localparam int unsigned PAUSE_CYC_DEF = 64;
	localparam int unsigned HASH_ROUNDS = 64;
	// ****************************************
	// Opcodes, modes, codes
	// ****************************************
	localparam logic [7:0] OPC_PAUSE = 8'h00;
	localparam logic [7:0] OPC_READ = 8'h02;
	localparam logic [7:0] OPC_BURN = 8'h10;
	localparam logic [7:0] OPC_GENP = 8'h20;
	localparam logic [7:0] MODE_ROM = 8'h00;
	localparam logic [7:0] MODE_FUSE = 8'h01;
	localparam logic [7:0] DECRYPT_OFF = 8'h00;
	localparam logic [7:0] DECRYPT_ON = 8'h01;
	localparam logic [15:0] BURN_SHORT_CODE = 16'h0000;
	localparam logic [7:0] RES_OK = 8'h00;
	localparam logic [7:0] RES_ERR = 8'h0f;
	localparam logic [63:0] MSG_LEN_BITS = 64'h0000_0000_0000_01bf;
	// ****************************************
	// Block sizes and fuse layout
	// ****************************************
	localparam int unsigned BLK_MAX = 20;
	localparam logic [5:0] LEN_READ = 6'h04;
	localparam logic [5:0] LEN_GENP = 6'h14;
	localparam logic [5:0] LEN_BURN = 6'h0f;
	localparam logic [5:0] LEN_PAUSE = 6'h04;
	localparam int unsigned HDR_BYTES = 4;
	localparam int unsigned FUSE_N = 88;
	localparam int unsigned LOCK_FUSE = 87;
	localparam int unsigned KEY_COUNT = 4;
	// ****************************************
	// Host register map (APB byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_LEN = 8'h04;
	localparam logic [7:0] REG_DATA0 = 8'h08;
	localparam logic [7:0] REG_DATA3 = 8'h14;
	localparam logic [7:0] REG_GO = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	localparam logic [7:0] REG_RESULT = 8'h20;
endpackage : fpc_pkg

// File: hdl/fpc_link_if.sv
// Byte-level command link between host controller and device
interface fpc_link_if;
	logic [7:0] hostByte;
	logic hostValid;
	logic hostLast;
	logic txReq;
	logic [7:0] devByte;
	logic devValid;
	logic devLast;
	logic devBusy;
	modport dev (
		input hostByte, hostValid, hostLast, txReq,
		output devByte, devValid, devLast, devBusy
	);
	modport host (
		output hostByte, hostValid, hostLast, txReq,
		input devByte, devValid, devLast, devBusy
	);
endinterface : fpc_link_if

// File: hdl/fpc_device.sv
// Device end: command execution for read, key derive, secure burn, pause
// Contract
// [RULE1] Read opcode 0x02 returns four bytes or error
// [RULE2] Mode 0 ROM needs addr bit1 zero; mode 1 fuses needs one
// [RULE3] Host sends only address bits zero and one
// [RULE4] Key derive opcode 0x20, zero param, 16-byte seed
// [RULE5] Hash key, 64 ones, 127 seed bits, pad, 447
// [RULE6] Digest valid set on completion, cleared by watchdog
// [RULE7] Key and digest never leave the device
// [RULE8] Key derive fails once lock fuse 87 burned
// [RULE9] Burn opcode 0x10, 11-byte map, one burns fuse
// [RULE10] First map bit received addresses fuse zero
// [RULE11] Decrypt one XORs map with 88 digest bits
// [RULE12] Host derives key right before encrypted burn
// [RULE13] Burn code 0x0000 short, 0xffff 262ms per fuse
// [RULE14] No check of burn count against watchdog
// [RULE15] Host splits long burns over repeated commands
// [RULE16] Burn refused with error if lock fuse burned
// [RULE17] Host burns lock fuse in final burn
// [RULE18] Secret fuses unreadable, status fuses readable
// [RULE19] Success of derive or burn returns zero byte
// [RULE20] Pause opcode 0x00, zero params, busy and deaf
// [RULE21] After pause, next transmit request gets zero
// [RULE22] Wrong block size skips execution with error
// [RULE23] Failed checks return one non-zero error byte
// [RULE24] Unknown burn codes use long burn time
//
// Implementation choices: the APB slave port and the address map.
module fpc_device
	import fpc_pkg::*;
#(
	parameter int unsigned BURN_SHORT_CYC = (BURN_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
	parameter int unsigned BURN_LONG_CYC = (BURN_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
	parameter int unsigned PAUSE_CYC = PAUSE_CYC_DEF,
	// Arbitrary contents
	parameter logic [63:0] ROM_IMAGE = 64'h1357_9bdf_2468_ace0,
	// Arbitrary values for fuses 88..127
	parameter logic [39:0] FIXED_FUSES = 40'h5a_c3a5_0f1e,
	// Arbitrary personalization keys
	parameter logic [KEY_COUNT*256-1:0] PERS_KEYS = {(KEY_COUNT*8){32'h6b2d_e197}}
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	fpc_link_if.dev link,
	// User side
	input wire logic wdExpire,
	output logic digestValid,
	output logic [FUSE_N-1:0] fuseBurned
);
	// ****************************************
	// State
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE, S_EXEC, S_HASH, S_BURN, S_PAUSE, S_DONE, S_SEND
	} fpc_dst_t;

	typedef struct packed {
		fpc_dst_t st;
		logic [5:0] cnt;
		logic [BLK_MAX-1:0][7:0] blk;
		logic [FUSE_N-1:0] burned;
		logic dVal;
		logic [255:0] digest;
		logic [6:0] idx;
		logic [31:0] waitCnt;
		logic [FUSE_N-1:0] map;
		logic [31:0] burnCyc;
		logic [3:0][7:0] rsp;
		logic [2:0] rspLen;
		logic [2:0] sIdx;
		logic [7:0] outByte;
		logic outValid;
		logic outLast;
	} fpc_dev_t;

	localparam logic [31:0] SHORT_C = 32'(BURN_SHORT_CYC);
	localparam logic [31:0] LONG_C = 32'(BURN_LONG_CYC);
	localparam logic [31:0] PAUSE_C = 32'(PAUSE_CYC);
	localparam logic [6:0] HASH_LAST = 7'(HASH_ROUNDS - 1);
	localparam logic [6:0] FUSE_END = 7'(FUSE_N);
	localparam logic [255:0] HASH_IV = {8{32'h9e37_79b9}};

	fpc_dev_t r_reg;
	fpc_dev_t r_next;
	logic [7:0] opc;
	logic [7:0] p1;
	logic [15:0] p2;
	logic [255:0] key;
	logic [127:0] seed;
	logic [511:0] msg;
	logic [31:0] word;
	logic [31:0] rdWord;
	logic [FUSE_N-1:0] mapRaw;
	logic [FUSE_N-1:0] pad;
	logic lenOk;
	logic ok;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_next = r_reg;
		r_next.outValid = 1'b0;
		r_next.outLast = 1'b0;
		opc = r_reg.blk[0];
		p1 = r_reg.blk[1];
		p2 = {r_reg.blk[3], r_reg.blk[2]};
		key = PERS_KEYS[p2[1:0] * 256 +: 256];
		for (int i = 0; i < 16; i++) begin
			seed[127 - 8 * i -: 8] = r_reg.blk[HDR_BYTES + i];
		end
		msg = {key, {64{1'b1}}, seed[127:1], 1'b1, MSG_LEN_BITS}; // [RULE5] [RULE4]
		word = msg[(4'hf - r_reg.idx[3:0]) * 32 +: 32];
		for (int i = 0; i < FUSE_N; i++) begin
			mapRaw[i] = r_reg.blk[HDR_BYTES + i / 8][i % 8]; // [RULE10]
			pad[i] = r_reg.digest[255 - i];
		end
		unique case (p2[1:0])
			2'h0: rdWord = ROM_IMAGE[31:0];
			2'h1: rdWord = ROM_IMAGE[63:32];
			2'h2: rdWord = {FIXED_FUSES[7:0], ~r_reg.burned[FUSE_N-1:64]}; // [RULE18]
			2'h3: rdWord = FIXED_FUSES[39:8];
		endcase
		lenOk = 1'b0;
		ok = 1'b0;
		if (wdExpire) begin
			r_next.dVal = 1'b0; // [RULE6]
			if (r_reg.st != S_HASH) begin
				r_next.digest = '0; // [RULE6]
			end
		end
		unique case (r_reg.st)
			S_IDLE: begin
				if (link.hostValid) begin
					if (r_reg.cnt < 6'(BLK_MAX)) begin
						r_next.blk[r_reg.cnt[4:0]] = link.hostByte;
					end
					if (r_reg.cnt != 6'h3f) begin
						r_next.cnt = r_reg.cnt + 6'h01;
					end
					if (link.hostLast) begin
						r_next.st = S_EXEC;
					end
				end
			end
			S_EXEC: begin
				r_next.cnt = '0;
				r_next.rsp = '0;
				r_next.rspLen = 3'h1;
				r_next.idx = '0;
				r_next.st = S_DONE;
				unique case (opc)
					OPC_READ: begin
						lenOk = r_reg.cnt == LEN_READ; // [RULE22]
						ok = lenOk && p2[15:2] == '0 && // [RULE3]
							((p1 == MODE_ROM && !p2[1]) || (p1 == MODE_FUSE && p2[1])); // [RULE2]
						if (ok) begin
							r_next.rsp = rdWord; // [RULE1]
							r_next.rspLen = 3'h4;
						end
					end
					OPC_GENP: begin
						lenOk = r_reg.cnt == LEN_GENP; // [RULE22]
						ok = lenOk && p1 == 8'h00 && !r_reg.burned[LOCK_FUSE]; // [RULE8] [RULE4]
						if (ok) begin
							r_next.digest = HASH_IV;
							r_next.st = S_HASH;
						end
					end
					OPC_BURN: begin
						lenOk = r_reg.cnt == LEN_BURN; // [RULE22]
						ok = lenOk && !r_reg.burned[LOCK_FUSE] && // [RULE16]
							(p1 == DECRYPT_OFF || (p1 == DECRYPT_ON && r_reg.dVal));
						if (ok) begin
							r_next.map = (p1 == DECRYPT_ON) ? mapRaw ^ pad : mapRaw; // [RULE11]
							r_next.burnCyc = (p2 == BURN_SHORT_CODE) ? SHORT_C : LONG_C; // [RULE13] [RULE24]
							r_next.waitCnt = '0;
							r_next.st = S_BURN;
						end
					end
					OPC_PAUSE: begin
						lenOk = r_reg.cnt == LEN_PAUSE; // [RULE22]
						ok = lenOk && p1 == 8'h00 && p2 == 16'h0000;
						if (ok) begin
							r_next.waitCnt = PAUSE_C - 32'h1;
							r_next.st = S_PAUSE; // [RULE20]
						end
					end
					default: ok = 1'b0;
				endcase
				if (!ok) begin
					r_next.rsp[0] = RES_ERR; // [RULE23]
				end
			end
			S_HASH: begin
				r_next.digest = {r_reg.digest[223:0],
					r_reg.digest[255:224] ^ (r_reg.digest[31:0] + word)};
				r_next.idx = r_reg.idx + 7'h01;
				if (r_reg.idx == HASH_LAST) begin
					r_next.dVal = 1'b1; // [RULE6]
					r_next.rsp[0] = RES_OK; // [RULE19]
					r_next.st = S_DONE;
				end
			end
			S_BURN: begin
				// Burn count is never weighed against the watchdog [RULE14]
				if (r_reg.waitCnt != '0) begin
					r_next.waitCnt = r_reg.waitCnt - 32'h1;
				end else if (r_reg.idx == FUSE_END) begin
					r_next.rsp[0] = RES_OK; // [RULE19]
					r_next.st = S_DONE;
				end else begin
					if (r_reg.map[r_reg.idx]) begin
						r_next.burned[r_reg.idx] = 1'b1; // [RULE9]
						r_next.waitCnt = r_reg.burnCyc - 32'h1;
					end
					r_next.idx = r_reg.idx + 7'h01;
				end
			end
			S_PAUSE: begin
				r_next.waitCnt = r_reg.waitCnt - 32'h1;
				if (r_reg.waitCnt == '0) begin
					r_next.st = S_DONE;
				end
			end
			S_DONE: begin
				if (link.txReq) begin
					r_next.sIdx = '0;
					r_next.st = S_SEND; // [RULE21]
				end
			end
			S_SEND: begin
				r_next.outValid = 1'b1;
				r_next.outByte = r_reg.rsp[r_reg.sIdx[1:0]];
				r_next.sIdx = r_reg.sIdx + 3'h1;
				if (r_reg.sIdx == r_reg.rspLen - 3'h1) begin
					r_next.outLast = 1'b1;
					r_next.st = S_IDLE;
				end
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r_reg <= '{st: S_IDLE, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Only result bytes reach the link; key and digest stay inside [RULE7]
	assign link.devByte = r_reg.outByte;
	assign link.devValid = r_reg.outValid;
	assign link.devLast = r_reg.outLast;
	assign link.devBusy = r_reg.st inside {S_EXEC, S_HASH, S_BURN, S_PAUSE}; // [RULE20]
	assign digestValid = r_reg.dVal;
	assign fuseBurned = r_reg.burned;
endmodule : fpc_device

// File: hdl/fpc_host.sv
// Host end: APB-programmed command sender and response collector
module fpc_host
	import fpc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link
	fpc_link_if.host link
);
	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {H_IDLE, H_SEND, H_POLL, H_RECV} fpc_hst_t;

	typedef struct packed {
		fpc_hst_t st;
		logic [31:0] cmd;
		logic [4:0] len;
		logic [3:0][31:0] data;
		logic [5:0] bIdx;
		logic [31:0] result;
		logic [2:0] rLen;
		logic done;
		logic [7:0] outByte;
		logic outValid;
		logic outLast;
		logic txReq;
		logic [31:0] rdata;
	} fpc_host_t;

	fpc_host_t r_reg;
	fpc_host_t r_next;
	logic [7:0] opc;
	logic [7:0] p1;
	logic [15:0] p2;
	logic [7:0] curByte;
	logic mapped;
	logic wrAcc;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_next = r_reg;
		r_next.outValid = 1'b0;
		r_next.outLast = 1'b0;
		opc = r_reg.cmd[7:0];
		p1 = r_reg.cmd[15:8];
		p2 = r_reg.cmd[31:16];
		if (opc == OPC_READ) begin
			p2 = p2 & 16'h0003; // [RULE3]
		end
		if (opc == OPC_PAUSE) begin
			p1 = 8'h00; // [RULE20]
			p2 = 16'h0000;
		end
		unique case (r_reg.bIdx)
			6'h00: curByte = opc;
			6'h01: curByte = p1;
			6'h02: curByte = p2[7:0];
			6'h03: curByte = p2[15:8];
			default: curByte = r_reg.data[r_reg.bIdx[5:2] - 4'h1][r_reg.bIdx[1:0] * 8 +: 8]; // [RULE10]
		endcase
		mapped = paddr inside {REG_CMD, REG_LEN, REG_GO, REG_STATUS, REG_RESULT} ||
			(paddr >= REG_DATA0 && paddr <= REG_DATA3 && paddr[1:0] == 2'h0);
		wrAcc = psel && penable && pwrite && mapped && r_reg.st == H_IDLE;
		if (psel && !penable) begin
			unique case (paddr)
				REG_CMD: r_next.rdata = r_reg.cmd;
				REG_LEN: r_next.rdata = {27'h0, r_reg.len};
				REG_STATUS: r_next.rdata = {25'h0, r_reg.rLen, 2'h0, r_reg.done, r_reg.st != H_IDLE};
				REG_RESULT: r_next.rdata = r_reg.result;
				default: r_next.rdata = (mapped && paddr >= REG_DATA0 && paddr <= REG_DATA3) ?
					r_reg.data[3'(paddr[4:2] - 3'h2)] : 32'h0;
			endcase
		end
		if (wrAcc) begin
			unique case (paddr)
				REG_CMD: r_next.cmd = pwdata;
				REG_LEN: r_next.len = pwdata[4:0];
				REG_GO: begin
					r_next.done = 1'b0;
					r_next.bIdx = '0;
					r_next.st = H_SEND;
				end
				REG_STATUS, REG_RESULT: r_next.done = r_reg.done;
				default: r_next.data[3'(paddr[4:2] - 3'h2)] = pwdata;
			endcase
		end
		unique case (r_reg.st)
			H_IDLE: r_next.txReq = 1'b0;
			H_SEND: begin
				// Encrypted burns rely on software ordering key derive first [RULE12] [RULE17]
				if (!link.devBusy) begin
					r_next.outValid = 1'b1;
					r_next.outByte = curByte;
					r_next.bIdx = r_reg.bIdx + 6'h01;
					if (r_reg.bIdx == 6'(HDR_BYTES) + 6'(r_reg.len) - 6'h01) begin
						r_next.outLast = 1'b1;
						r_next.result = '0;
						r_next.rLen = '0;
						r_next.st = H_POLL;
					end
				end
			end
			H_POLL, H_RECV: begin
				r_next.txReq = r_reg.st == H_POLL && !link.devValid; // [RULE21]
				if (link.devValid) begin
					r_next.result[r_reg.rLen[1:0] * 8 +: 8] = link.devByte;
					r_next.rLen = r_reg.rLen + 3'h1;
					r_next.st = H_RECV;
					if (link.devLast) begin
						r_next.done = 1'b1;
						r_next.txReq = 1'b0;
						r_next.st = H_IDLE;
					end
				end
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r_reg <= '{st: H_IDLE, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = r_reg.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign link.hostByte = r_reg.outByte;
	assign link.hostValid = r_reg.outValid;
	assign link.hostLast = r_reg.outLast;
	assign link.txReq = r_reg.txReq;
endmodule : fpc_host

// File: tb/fpc_link_properties.sv
// Link-level checker for the fuse/ROM command link
module fpc_link_properties
	import fpc_pkg::*;
#(
	parameter int unsigned PAUSE_CYC = PAUSE_CYC_DEF
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	input wire logic [7:0] hostByte,
	input wire logic hostValid,
	input wire logic hostLast,
	input wire logic txReq,
	input wire logic [7:0] devByte,
	input wire logic devValid,
	input wire logic devLast,
	input wire logic devBusy
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Block capture
	// ****
	logic [5:0] blkCnt;
	logic [5:0] blkLen;
	logic [31:0] hdr;
	logic [2:0] rCnt;
	logic [15:0] busyCnt;
	logic readOk;
	assign readOk = blkLen == 6'h04 && hdr[31:18] == 14'h0 &&
		(hdr[15:8] == MODE_ROM && !hdr[17] || hdr[15:8] == MODE_FUSE && hdr[17]);
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			blkCnt <= 6'h00;
			blkLen <= 6'h00;
			hdr <= 32'h0;
			rCnt <= 3'h0;
			busyCnt <= 16'h0;
		end else begin
			if (hostValid) begin
				blkCnt <= hostLast ? 6'h00 : blkCnt + 6'h01;
				if (blkCnt < 6'h04) hdr[8*blkCnt[1:0]+:8] <= hostByte;
				if (hostLast) blkLen <= blkCnt + 6'h01;
			end
			if (devValid) rCnt <= devLast ? 3'h0 : rCnt + 3'h1;
			busyCnt <= devBusy ? busyCnt + 16'h1 : 16'h0;
		end
	end
	// ****
	// Properties
	// ****
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_busy_after_last: assert property (hostValid && hostLast |=> devBusy)
		else $error("device not busy after block end");
	a_busy_cause: assert property ($rose(devBusy) |-> $past(hostLast))
		else $error("device busy without a block");
	a_quiet_busy: assert property (devBusy |-> !devValid)
		else $error("response while busy");
	a_resp_burst: assert property (devValid && !devLast |=> devValid)
		else $error("gap inside response");
	a_resp_on_tx: assert property ($rose(devValid) |-> $past(txReq) || $past(txReq, 2))
		else $error("response without transmit request");
	a_read_len: assert property (devValid && devLast && hdr[7:0] == OPC_READ |->
		(rCnt == 3'h3) == readOk) else $error("read response length wrong");
	a_read_err: assert property (devValid && devLast && hdr[7:0] == OPC_READ && !readOk |->
		devByte == RES_ERR) else $error("illegal read not answered by error");
	a_pause_zero: assert property (devValid && blkLen == 6'h04 && hdr == 32'h0 |->
		devLast && devByte == RES_OK) else $error("pause result not zero");
	a_pause_long: assert property ($fell(devBusy) && blkLen == 6'h04 && hdr == 32'h0 |->
		busyCnt >= PAUSE_CYC) else $error("pause too short");
endmodule : fpc_link_properties

// File: tb/test_fuse_rom_personalization_cmds.sv
// Self-checking bench: host and device joined over the command link
module test_fuse_rom_personalization_cmds import fpc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] ROM = 64'h0123_4567_89ab_cdef;
	localparam logic [39:0] FIX = 40'h9c_1234_5678;
	localparam logic [15:0] CODES [3] = '{16'h0000, 16'hffff, 16'h1234};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic perr;
	logic wdExpire = 1'b0;
	logic digestValid;
	logic [FUSE_N-1:0] fuseBurned;
	logic [87:0] burnModel = '0;
	logic [31:0] seed = 32'h5;
	logic [31:0] rd;
	logic [2:0] rLen;
	int n_fail = 0;
	int comparisons = 0;
	fpc_link_if u_fpc_link_if ();
	fpc_device #(.BURN_SHORT_CYC(4), .BURN_LONG_CYC(8), .PAUSE_CYC(8), .ROM_IMAGE(ROM),
		.FIXED_FUSES(FIX)) u_fpc_device (.core_clk(core_clk), .rst_n(rst_n),
		.link(u_fpc_link_if), .wdExpire(wdExpire), .digestValid(digestValid),
		.fuseBurned(fuseBurned));
	fpc_host u_fpc_host (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(u_fpc_link_if));
	fpc_link_properties #(.PAUSE_CYC(8)) u_fpc_link_properties (.core_clk(core_clk),
		.rst_n(rst_n), .hostByte(u_fpc_link_if.hostByte), .hostValid(u_fpc_link_if.hostValid),
		.hostLast(u_fpc_link_if.hostLast), .txReq(u_fpc_link_if.txReq),
		.devByte(u_fpc_link_if.devByte), .devValid(u_fpc_link_if.devValid),
		.devLast(u_fpc_link_if.devLast), .devBusy(u_fpc_link_if.devBusy));
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [87:0] got, input logic [87:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_fail++;
			report_and_stop();
		end
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic cmd(input logic [31:0] hdr, input logic [4:0] len, input logic [127:0] dat);
		int i;
		apb(1'b1, REG_CMD, hdr);
		apb(1'b1, REG_LEN, {27'h0, len});
		for (int w = 0; w < 4; w++) apb(1'b1, REG_DATA0 + 8'(4 * w), dat[32*w+:32]);
		apb(1'b1, REG_GO, 32'h1);
		for (i = 0; i < 400; i++) begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (rd[1:0] === 2'b10) break;
		end
		if (i == 400) begin
			n_fail++;
			report_and_stop();
		end
		rLen = rd[6:4];
		apb(1'b0, REG_RESULT, 32'h0);
	endtask : cmd
	task automatic expect1(input logic [31:0] hdr, input logic [4:0] len, input logic [127:0] dat,
		input logic [7:0] exp);
		cmd(hdr, len, dat);
		check(88'(rLen), 88'h1, "response length");
		check(88'(rd[7:0]), 88'(exp), "result byte");
	endtask : expect1
	function automatic logic [32:0] expRead(input logic [7:0] mode, input logic [15:0] addr);
		logic [15:0] a;
		// Host sends only address bits zero and one
		a = addr & 16'h0003;
		if (mode == MODE_ROM && a < 16'h2) return {1'b1, ROM[32*a[0]+:32]};
		if (mode == MODE_FUSE && a == 16'h2) return {1'b1, FIX[7:0], ~burnModel[87:64]};
		if (mode == MODE_FUSE && a == 16'h3) return {1'b1, FIX[39:8]};
		return {25'h0, RES_ERR};
	endfunction : expRead
	task automatic readChk(input logic [7:0] mode, input logic [15:0] addr);
		logic [32:0] e;
		e = expRead(mode, addr);
		cmd({addr, mode, OPC_READ}, 5'h0, '0);
		check(88'(rLen), e[32] ? 88'h4 : 88'h1, "read length");
		check(88'(e[32] ? rd : {24'h0, rd[7:0]}), 88'(e[31:0]), "read data");
	endtask : readChk
	// ****
	// Main sequence
	// ****
	initial begin
		logic [127:0] m;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		readChk(MODE_ROM, 16'h0);
		readChk(MODE_ROM, 16'h1);
		readChk(MODE_FUSE, 16'h3);
		readChk(MODE_ROM, 16'h2);
		readChk(MODE_FUSE, 16'h1);
		readChk(8'h02, 16'h0);
		readChk(MODE_ROM, 16'h0100);
		for (int k = 0; k < 8; k++) begin
			m[31:0] = rnd();
			readChk({7'h0, m[0]}, {14'h0, m[2:1]});
		end
		expect1({16'h0, MODE_ROM, OPC_READ}, 5'h1, '0, RES_ERR);
		expect1({24'h0, 8'h55}, 5'h0, '0, RES_ERR);
		expect1(32'h0, 5'h0, '0, RES_OK);
		expect1(32'h0, 5'h2, '0, RES_ERR);
		apb(1'b0, 8'h40, 32'h0);
		check(88'({perr, rd}), 88'h1_0000_0000, "unmapped access");
		$display("reads and pause done");
		for (int j = 0; j < 3; j++) begin
			m = {rnd(), rnd(), rnd(), rnd()} & {41'h0, {87{1'b1}}};
			expect1({CODES[j], DECRYPT_OFF, OPC_BURN}, 5'h0b, m, RES_OK);
			burnModel |= m[87:0];
			check(fuseBurned, burnModel, "fuses after burn");
		end
		readChk(MODE_FUSE, 16'h2);
		$display("plain burns done");
		m = {rnd(), rnd(), rnd(), rnd()};
		expect1({16'h0, 8'h01, OPC_GENP}, 5'h10, m, RES_ERR);
		expect1({16'h0, DECRYPT_ON, OPC_BURN}, 5'h0b, m, RES_ERR);
		expect1({16'h2, 8'h00, OPC_GENP}, 5'h0f, m, RES_ERR);
		expect1({16'h2, 8'h00, OPC_GENP}, 5'h10, m, RES_OK);
		check(88'(digestValid), 88'h1, "digest flag set");
		expect1({16'h0, 8'h02, OPC_BURN}, 5'h0b, m, RES_ERR);
		@(posedge core_clk);
		wdExpire <= 1'b1;
		@(posedge core_clk);
		wdExpire <= 1'b0;
		@(posedge core_clk);
		check(88'(digestValid), 88'h0, "digest flag cleared");
		expect1({16'h0, DECRYPT_ON, OPC_BURN}, 5'h0b, m, RES_ERR);
		check(fuseBurned, burnModel, "no burn on refusal");
		$display("key derive done");
		m = 128'h80_0000_0000_0000_0000_0000;
		expect1({16'h0, DECRYPT_OFF, OPC_BURN}, 5'h0b, m, RES_OK);
		burnModel[87] = 1'b1;
		expect1({16'h0, DECRYPT_OFF, OPC_BURN}, 5'h0b, ~m, RES_ERR);
		check(fuseBurned, burnModel, "locked burn left fuses");
		expect1({16'h1, 8'h00, OPC_GENP}, 5'h10, m, RES_ERR);
		readChk(MODE_FUSE, 16'h2);
		$display("lock done");
		report_and_stop();
	end
endmodule : test_fuse_rom_personalization_cmds
